/* src/tcma_regs.svh */
// Transfer controller mode/address constants: field positions and codes.
// Assumes inclusion by the design file only.
`ifndef TCMA_REGS_SVH
`define TCMA_REGS_SVH
`define TCMA_MA_SRC_HI 7
`define TCMA_MA_SRC_LO 6
`define TCMA_MA_DST_HI 5
`define TCMA_MA_DST_LO 4
`define TCMA_MA_MODE_HI 3
`define TCMA_MA_MODE_LO 2
`define TCMA_MA_AREA 1
`define TCMA_MA_SIZE 0
`define TCMA_MB_CHAIN 7
`define TCMA_MB_ISEL 6
`define TCMA_MODE_NORMAL 2'h0
`define TCMA_MODE_REPEAT 2'h1
`define TCMA_MODE_BLOCK 2'h2
`define TCMA_STEP_BYTE 24'h000001
`define TCMA_STEP_WORD 24'h000002
`define TCMA_CNT16_ZERO 16'h0000
`define TCMA_CNT8_ZERO 8'h00
`endif

/* src/tcma_pkg.sv */
// Types shared by the transfer controller mode/address block.
// Assumes tcma_regs.svh on the include path.
package tcma_pkg;
   typedef enum logic [1:0] {tcma_upd_fixed, tcma_upd_inc, tcma_upd_dec}
      tcma_upd_t;
   typedef enum logic [2:0] {tcma_idle, tcma_load, tcma_move, tcma_store,
      tcma_done} tcma_state_t;
endpackage : tcma_pkg

/* src/tcma_ctrl.sv */
// Transfer controller mode/address engine: loads transfer information,
// performs one move, updates addresses and counters, writes back.
// Assumes the info memory and the bus answer with one-cycle pulses.
// Functional notes
// - Source update: fixed, increment or decrement
// - Destination update works the same way
// - Step is one byte or two bytes
// - Mode field: normal, repeat, block; 11 unused, handled as repeat
// - Area select: 0 destination, 1 source side
// - Size bit chooses byte or word
// - Chain enable reads next info, transfers again
// - Chained transfer skips count end, flag, enable clear
// - Interrupt select 0 clears activating source flag unless count ended
// - Interrupt select 1 leaves source flag set
// - Source address is 24 bits wide
// - Destination address is 24 bits wide
// - Normal mode: 16-bit counter ends at zero
// - Repeat/block: low counter reloads from holding value
// - Block mode: block counter ends at zero
// - Clear source enable on end or select set
`timescale 1ns/1ps
`include "tcma_regs.svh"
module tcma_ctrl
   import tcma_pkg::*;
#(
   parameter int AW = 24
)(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic activate,
   input wire logic [7:0] info_mode_a,
   input wire logic [7:0] info_mode_b,
   input wire logic [AW-1:0] info_src,
   input wire logic [AW-1:0] info_dst,
   input wire logic [15:0] info_cnt_a,
   input wire logic [15:0] info_cnt_b,
   input wire logic info_valid,
   input wire logic bus_done,
   output logic info_req,
   output logic bus_req,
   output logic [AW-1:0] bus_src,
   output logic [AW-1:0] bus_dst,
   output logic bus_word,
   output logic wb_valid,
   output logic [AW-1:0] wb_src,
   output logic [AW-1:0] wb_dst,
   output logic [15:0] wb_cnt_a,
   output logic [15:0] wb_cnt_b,
   output logic clear_src_flag,
   output logic clear_src_enable,
   output logic busy
);
   tcma_state_t state_reg;
   logic [7:0] mode_a_reg;
   logic chain_reg;
   logic isel_reg;
   logic [AW-1:0] src_reg;
   logic [AW-1:0] dst_reg;
   logic [15:0] cnt_a_reg;
   logic [15:0] cnt_b_reg;
   logic [1:0] xfer_mode;
   logic end_next;
   logic [AW-1:0] src_next;
   logic [AW-1:0] dst_next;
   logic [15:0] cnt_a_next;
   logic [15:0] cnt_b_next;
   logic blk_wrap;

   // Decode an update field pair into fixed/inc/dec
   function automatic tcma_upd_t upd_dec(input logic hi, input logic lo);
      if (!hi)
      begin
         return tcma_upd_fixed;
      end
      return lo ? tcma_upd_dec : tcma_upd_inc;
   endfunction : upd_dec

   // Apply one step to an address
   function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a,
      input tcma_upd_t u, input logic word);
      logic [AW-1:0] st;
      st = word ? AW'(`TCMA_STEP_WORD) : AW'(`TCMA_STEP_BYTE);
      unique case (u)
         tcma_upd_inc: return a + st;
         tcma_upd_dec: return a - st;
         default: return a;
      endcase
   endfunction : step_addr

   assign xfer_mode = mode_a_reg[`TCMA_MA_MODE_HI:`TCMA_MA_MODE_LO];

   // Block wraps when low counter hits zero after this move
   assign blk_wrap = (cnt_a_reg[7:0] == 8'h01);

   always_comb
   begin
      src_next = step_addr(src_reg,
         upd_dec(mode_a_reg[`TCMA_MA_SRC_HI], mode_a_reg[`TCMA_MA_SRC_LO]),
         mode_a_reg[`TCMA_MA_SIZE]);
      dst_next = step_addr(dst_reg,
         upd_dec(mode_a_reg[`TCMA_MA_DST_HI], mode_a_reg[`TCMA_MA_DST_LO]),
         mode_a_reg[`TCMA_MA_SIZE]);
      cnt_a_next = cnt_a_reg;
      cnt_b_next = cnt_b_reg;
      end_next = 1'b0;
      if (xfer_mode == `TCMA_MODE_NORMAL)
      begin
         cnt_a_next = cnt_a_reg - 16'h0001;
         end_next = (cnt_a_next == `TCMA_CNT16_ZERO);
      end
      else
      begin
         if (blk_wrap)
         begin
            cnt_a_next = {cnt_a_reg[15:8], cnt_a_reg[15:8]};
         end
         else
         begin
            cnt_a_next = {cnt_a_reg[15:8], cnt_a_reg[7:0] - 8'h01};
         end
         if (xfer_mode == `TCMA_MODE_BLOCK && blk_wrap)
         begin
            cnt_b_next = cnt_b_reg - 16'h0001;
            end_next = (cnt_b_next == `TCMA_CNT16_ZERO);
            // Block area address is held, not stepped, on the move that ends a block
            if (mode_a_reg[`TCMA_MA_AREA])
            begin
               src_next = step_addr(src_reg, tcma_upd_fixed, 1'b0);
            end
            else
            begin
               dst_next = step_addr(dst_reg, tcma_upd_fixed, 1'b0);
            end
         end
      end
   end

   // Sequencer
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= tcma_idle;
      end
      else
      begin
         unique case (state_reg)
            tcma_idle: if (activate) state_reg <= tcma_load;
            tcma_load: if (info_valid) state_reg <= tcma_move;
            tcma_move: if (bus_done) state_reg <= tcma_store;
            tcma_store: state_reg <= chain_reg ? tcma_load : tcma_done;
            tcma_done: state_reg <= tcma_idle;
         endcase
      end
   end

   // Transfer information load and update
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         mode_a_reg <= 8'h00;
         chain_reg <= 1'b0;
         isel_reg <= 1'b0;
         src_reg <= '0;
         dst_reg <= '0;
         cnt_a_reg <= 16'h0000;
         cnt_b_reg <= 16'h0000;
      end
      else if (state_reg == tcma_load && info_valid)
      begin
         mode_a_reg <= info_mode_a;
         chain_reg <= info_mode_b[`TCMA_MB_CHAIN];
         isel_reg <= info_mode_b[`TCMA_MB_ISEL];
         src_reg <= info_src;
         dst_reg <= info_dst;
         cnt_a_reg <= info_cnt_a;
         cnt_b_reg <= info_cnt_b;
      end
      else if (state_reg == tcma_move && bus_done)
      begin
         src_reg <= src_next;
         dst_reg <= dst_next;
         cnt_a_reg <= cnt_a_next;
         cnt_b_reg <= cnt_b_next;
      end
   end

   // End-of-count latch for the final transfer of an activation
   logic end_reg;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         end_reg <= 1'b0;
      end
      else if (state_reg == tcma_move && bus_done)
      begin
         end_reg <= end_next;
      end
   end

   // Outputs
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         info_req <= 1'b0;
         bus_req <= 1'b0;
         bus_src <= '0;
         bus_dst <= '0;
         bus_word <= 1'b0;
         wb_valid <= 1'b0;
         wb_src <= '0;
         wb_dst <= '0;
         wb_cnt_a <= 16'h0000;
         wb_cnt_b <= 16'h0000;
         clear_src_flag <= 1'b0;
         clear_src_enable <= 1'b0;
         busy <= 1'b0;
      end
      else
      begin
         // Held until the info memory answers
         info_req <= (state_reg == tcma_idle && activate) ||
            (state_reg == tcma_store && chain_reg) ||
            (state_reg == tcma_load && !info_valid);
         bus_req <= (state_reg == tcma_load && info_valid) ||
            (state_reg == tcma_move && !bus_done);
         bus_src <= (state_reg == tcma_load) ? info_src : src_reg;
         bus_dst <= (state_reg == tcma_load) ? info_dst : dst_reg;
         bus_word <= (state_reg == tcma_load) ?
            info_mode_a[`TCMA_MA_SIZE] : mode_a_reg[`TCMA_MA_SIZE];
         wb_valid <= (state_reg == tcma_move && bus_done);
         if (state_reg == tcma_move && bus_done)
         begin
            wb_src <= src_next;
            wb_dst <= dst_next;
            wb_cnt_a <= cnt_a_next;
            wb_cnt_b <= cnt_b_next;
         end
         // Last link only; chained links skip these
         clear_src_flag <= (state_reg == tcma_store) && !chain_reg &&
            !isel_reg && !end_reg;
         clear_src_enable <= (state_reg == tcma_store) && !chain_reg &&
            (isel_reg || end_reg);
         busy <= (state_reg != tcma_idle) || activate;
      end
   end
endmodule : tcma_ctrl

/* tb/tcma_ctrl_sva.sv */
// Port checker for the transfer engine, bound to every tcma_ctrl.
// Assumes transfer info inputs held steady while a transfer runs.
`timescale 1ns/1ps
module tcma_ctrl_sva (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic activate,
   input wire logic busy,
   input wire logic info_req,
   input wire logic info_valid,
   input wire logic bus_req,
   input wire logic bus_done,
   input wire logic wb_valid,
   input wire logic [23:0] bus_src,
   input wire logic [23:0] wb_src,
   input wire logic [7:0] info_mode_a,
   input wire logic [7:0] info_mode_b,
   input wire logic [15:0] info_cnt_a,
   input wire logic clear_src_flag,
   input wire logic clear_src_enable
);
   wire logic [23:0] st = info_mode_a[0] ? 24'h2 : 24'h1;
   // Mode-b bits as taken at the info load edge
   logic ch_seen;
   logic is_seen;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         ch_seen <= 1'b0;
         is_seen <= 1'b0;
      end
      else if (info_req && info_valid)
      begin
         ch_seen <= info_mode_b[7];
         is_seen <= info_mode_b[6];
      end
   end
   wire logic ch = wb_valid && ch_seen;
   wire logic wrap = info_mode_a[3:2] == 2'h2 && info_cnt_a[7:0] == 8'h01;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_st; activate && !busy |=> info_req && busy; endproperty
   a_st: assert property (p_st) else $error("no info request");
   property p_bq; info_req && info_valid |=> bus_req; endproperty
   a_bq: assert property (p_bq) else $error("no move request");
   property p_wb; bus_req && bus_done |=> wb_valid && !bus_req; endproperty
   a_wb: assert property (p_wb) else $error("no write-back");
   property p_up; wb_valid && info_mode_a[7] |->
      wb_src == (wrap && info_mode_a[1] ? bus_src :
      info_mode_a[6] ? bus_src - st : bus_src + st); endproperty
   a_up: assert property (p_up) else $error("source step");
   property p_fx; wb_valid && !info_mode_a[7] |-> wb_src == bus_src;
   endproperty
   a_fx: assert property (p_fx) else $error("source moved");
   property p_ch; ch |-> ##[1:3] info_req; endproperty
   a_ch: assert property (p_ch) else $error("no chain read");
   property p_nc; ch |=> (!clear_src_flag && !clear_src_enable) [*3];
   endproperty
   a_nc: assert property (p_nc) else $error("chain cleared");
   property p_i1; wb_valid && !ch_seen && is_seen |->
      ##[1:3] clear_src_enable && !clear_src_flag; endproperty
   a_i1: assert property (p_i1) else $error("select one");
endmodule : tcma_ctrl_sva
bind tcma_ctrl tcma_ctrl_sva u_sva (.*);

/* tb/tcma_far.sv */
// Far side stand-in: transfer info memory and internal bus.
// Answers each held request with a one-cycle pulse, 0 to 3 cycles late.
`timescale 1ns/1ps
module tcma_far (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic info_req,
   input wire logic bus_req,
   output logic info_valid = 1'h0,
   output logic bus_done = 1'h0
);
   int wi = 0;
   int wb = 0;
   always @(negedge ref_clk)
   begin
      wi = info_req && !info_valid && !sys_rst ? wi + 1 : 0;
      wb = bus_req && !bus_done && !sys_rst ? wb + 1 : 0;
      info_valid <= wi > $urandom_range(3);
      bus_done <= wb > $urandom_range(3);
   end
endmodule : tcma_far

/* tb/tb_top.sv */
// Bench: random transfer info checked against an update model.
// Assumes tcma_far answers the info and move requests.
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 0, sys_rst = 1, activate = 0;
   logic [7:0] info_mode_a = 0, info_mode_b = 0;
   logic [23:0] info_src = 0, info_dst = 0;
   logic [15:0] info_cnt_a = 0, info_cnt_b = 0;
   logic info_valid, bus_done, info_req, bus_req, bus_word, wb_valid;
   logic clear_src_flag, clear_src_enable, busy;
   logic [23:0] bus_src, bus_dst, wb_src, wb_dst;
   logic [15:0] wb_cnt_a, wb_cnt_b;
   int mismatches = 0, num_checks = 0;
   always #50 ref_clk = ~ref_clk;
   tcma_ctrl dut (.*);
   tcma_far far (.*);
   task automatic chk(string n, logic [23:0] e, logic [23:0] s);
      num_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask : chk
   function automatic logic [23:0] nxt(logic [1:0] m, logic [23:0] a);
      logic [23:0] s;
      s = info_mode_a[0] ? 24'h2 : 24'h1;
      return !m[1] ? a : m[0] ? a - s : a + s;
   endfunction : nxt
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic run;
      logic [15:0] ea, eb;
      logic [23:0] es, ed;
      logic fin, ch, wrap, blk;
      int n;
      activate <= 1'h1;
      repeat (2) @(negedge ref_clk);
      activate <= 1'h0;
      do
      begin
         ch = info_mode_b[7];
         n = 0;
         while (wb_valid !== 1'h1 && n < 50)
         begin
            @(negedge ref_clk);
            n++;
         end
         wrap = info_mode_a[3:2] != 2'h0 && info_cnt_a[7:0] == 8'h1;
         blk = wrap && info_mode_a[3:2] == 2'h2;
         ea = info_mode_a[3:2] == 2'h0 ? info_cnt_a - 16'h1 :
            wrap ? {2{info_cnt_a[15:8]}} :
            {info_cnt_a[15:8], info_cnt_a[7:0] - 8'h1};
         eb = blk ? info_cnt_b - 16'h1 : info_cnt_b;
         fin = info_mode_a[3:2] == 2'h0 ? ea == 16'h0 : blk && eb == 16'h0;
         es = blk && info_mode_a[1] ? info_src :
            nxt(info_mode_a[7:6], info_src);
         ed = blk && !info_mode_a[1] ? info_dst :
            nxt(info_mode_a[5:4], info_dst);
         chk("wb_valid", 1'h1, wb_valid);
         chk("bus_src", info_src, bus_src);
         chk("bus_dst", info_dst, bus_dst);
         chk("bus_word", info_mode_a[0], bus_word);
         chk("wb_src", es, wb_src);
         chk("wb_dst", ed, wb_dst);
         chk("wb_cnt_a", ea, wb_cnt_a);
         chk("wb_cnt_b", eb, wb_cnt_b);
         info_mode_b[7] = 1'h0;
         @(negedge ref_clk);
         chk("clr_flag", !ch && !info_mode_b[6] && !fin, clear_src_flag);
         chk("clr_en", !ch && (info_mode_b[6] || fin), clear_src_enable);
      end while (ch);
      repeat (4) @(negedge ref_clk);
      chk("busy", 1'h0, busy);
   endtask : run
   initial
   begin
      #2000000;
      mismatches++;
      report_and_stop;
   end
   initial
   begin
      void'($urandom(97));
      repeat (10) @(negedge ref_clk);
      sys_rst <= 1'h0;
      @(negedge ref_clk);
      chk("busy", 1'h0, busy);
      for (int t = 0; t < 60; t++)
      begin
         info_mode_a = 8'($urandom);
         if (info_mode_a[3:2] == 2'h3)
            info_mode_a[3] = 1'h0;
         info_mode_b = 8'($urandom_range(3)) << 6;
         info_src = 24'($urandom) & ~24'(info_mode_a[0]);
         info_dst = 24'($urandom) & ~24'(info_mode_a[0]);
         info_cnt_a = info_mode_a[3:2] == 2'h0 ? 16'($urandom_range(3, 1)) :
            {8'($urandom), 8'($urandom_range(3, 1))};
         info_cnt_b = 16'($urandom_range(2, 1));
         run();
      end
      report_and_stop;
   end
endmodule : tb_top
